// [src/tpic_timer.sv]
// Sixteen-bit timer with modulation mode, low-power handling and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "tpic_cfg.svh"

module tpic_timer (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // AXI4-Lite write
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Timer pins
  input  wire logic        captureOnePin,
  input  wire logic        captureTwoPin,
  input  wire logic        extClockPin,
  output logic             compareOnePinOut,
  output logic             compareOnePinOe,
  output logic             compareTwoPinOut,
  output logic             compareTwoPinOe,
  // CPU side
  input  wire logic        cpuIntMask,
  input  wire logic        haltMode,
  input  wire logic        waitMode,
  output logic             timerIrq,
  output logic             wakeFromWait
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic edgeSeen(input logic cur,
                                    input logic prev,
                                    input logic rise);
    edgeSeen = rise ? (cur & ~prev) : (~cur & prev);
  endfunction

  function automatic logic touched(input logic       re,
                                   input logic       we,
                                   input logic [5:0] ra,
                                   input logic [5:0] wa,
                                   input logic [5:0] x);
    touched = (re && ra == x) || (we && wa == x);
  endfunction

  function automatic logic isBad(input logic [31:0] a);
    isBad = (|a[31:6]) || (a[5:0] > `TPIC_OFS_LAST);
  endfunction

  localparam tpic_pkg::tpic_state_t ST_RST = '{
    cnt:     `TPIC_CNT_RST,
    oc1:     `TPIC_OC_RST,
    oc2:     `TPIC_OC_RST,
    default: '0
  };

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  tpic_pkg::tpic_state_t st_reg;
  tpic_pkg::tpic_state_t st_next;
  tpic_pkg::tpic_bus_t   bus_reg;
  tpic_pkg::tpic_bus_t   bus_next;

  logic       wrEn;
  logic [5:0] wrAddr;
  logic [7:0] wrData;
  logic       rdEn;
  logic [5:0] rdAddr;
  logic [7:0] rdByte;
  logic       arAcc;

  logic       run;
  logic       pwm;
  logic       single_pulse_select;
  logic [2:0] preLast;
  logic       tick;
  logic       m1;
  logic       m2;
  logic       e1;
  logic       e2;
  logic       eExt;
  logic       exitHalt;

  // ----------------------------------------------------------------------
  // Tick and match terms
  // ----------------------------------------------------------------------
  assign run      = ce & ~haltMode;
  assign pwm      = st_reg.cr2[`TPIC_CR2_PWM];
  assign single_pulse_select      = st_reg.cr2[`TPIC_CR2_OPM] & ~pwm;
  assign exitHalt = st_reg.haltQ & ~haltMode;

  always_comb begin
    unique case (st_reg.cr2[`TPIC_CR2_CCHI:`TPIC_CR2_CCLO])
      2'b00:   preLast = `TPIC_PRE_LAST4;
      2'b01:   preLast = `TPIC_PRE_LAST2;
      2'b10:   preLast = `TPIC_PRE_LAST8;
      2'b11:   preLast = `TPIC_PRE_LAST4;
    endcase
  end

  assign eExt = edgeSeen(extClockPin, st_reg.extQ, st_reg.cr2[`TPIC_CR2_EXED]);
  assign tick = (st_reg.cr2[`TPIC_CR2_CCHI:`TPIC_CR2_CCLO] == 2'b11) ?
                eExt : (st_reg.pre == preLast);
  assign e1   = edgeSeen(captureOnePin, st_reg.cap1Q, st_reg.cr1[`TPIC_CR1_IED1]);
  assign e2   = edgeSeen(captureTwoPin, st_reg.cap2Q, st_reg.cr2[`TPIC_CR2_IED2]);
  assign m1   = tick & ~st_reg.inh[0] & (st_reg.cnt == st_reg.oc1);
  assign m2   = tick & ~st_reg.inh[1] & (st_reg.cnt == st_reg.oc2);

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  assign s_axi_awready = ce & ~bus_reg.awHave & ~bus_reg.bvalid;
  assign s_axi_wready  = ce & ~bus_reg.wHave & ~bus_reg.bvalid;
  assign s_axi_arready = ce & ~bus_reg.rvalid;
  assign arAcc         = s_axi_arvalid & s_axi_arready;

  always_comb begin
    unique case (s_axi_araddr[5:0])
      `TPIC_OFS_CR1:  rdByte = st_reg.cr1;
      `TPIC_OFS_CR2:  rdByte = st_reg.cr2;
      `TPIC_OFS_SR:   rdByte = {st_reg.sr[7:3], 3'h0};
      `TPIC_OFS_IC1H: rdByte = st_reg.ic1[15:8];
      `TPIC_OFS_IC1L: rdByte = st_reg.ic1[7:0];
      `TPIC_OFS_OC1H: rdByte = st_reg.oc1[15:8];
      `TPIC_OFS_OC1L: rdByte = st_reg.oc1[7:0];
      `TPIC_OFS_OC2H: rdByte = st_reg.oc2[15:8];
      `TPIC_OFS_OC2L: rdByte = st_reg.oc2[7:0];
      `TPIC_OFS_CH:   rdByte = st_reg.cnt[15:8];
      `TPIC_OFS_CL:   rdByte = st_reg.cnt[7:0];
      `TPIC_OFS_ACH:  rdByte = st_reg.cnt[15:8];
      `TPIC_OFS_ACL:  rdByte = st_reg.cnt[7:0];
      `TPIC_OFS_IC2H: rdByte = st_reg.ic2[15:8];
      `TPIC_OFS_IC2L: rdByte = st_reg.ic2[7:0];
      default:        rdByte = 8'h00;
    endcase
  end

  always_comb begin
    bus_next = bus_reg;
    wrEn     = 1'b0;
    wrAddr   = bus_reg.awAddr;
    wrData   = bus_reg.wData;
    rdEn     = 1'b0;
    rdAddr   = s_axi_araddr[5:0];
    if (s_axi_awvalid && s_axi_awready) begin
      bus_next.awHave = 1'b1;
      bus_next.awAddr = s_axi_awaddr[5:0];
      bus_next.awBad  = isBad(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      bus_next.wHave = 1'b1;
      bus_next.wData = s_axi_wdata[7:0];
      bus_next.wEn   = s_axi_wstrb[0];
    end
    if (ce && bus_next.awHave && bus_next.wHave) begin
      wrEn            = ~bus_next.awBad & bus_next.wEn;
      wrAddr          = bus_next.awAddr;
      wrData          = bus_next.wData;
      bus_next.awHave = 1'b0;
      bus_next.wHave  = 1'b0;
      bus_next.bvalid = 1'b1;
      bus_next.bresp  = bus_next.awBad ? 2'b10 : 2'b00;
    end else if (ce && bus_reg.bvalid && s_axi_bready) begin
      bus_next.bvalid = 1'b0;
    end
    if (arAcc) begin
      rdEn            = ~isBad(s_axi_araddr);
      bus_next.rvalid = 1'b1;
      bus_next.rdata  = isBad(s_axi_araddr) ? 8'h00 : rdByte;
      bus_next.rresp  = isBad(s_axi_araddr) ? 2'b10 : 2'b00;
    end else if (ce && bus_reg.rvalid && s_axi_rready) begin
      bus_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      bus_reg <= '0;
    end else if (ce) begin
      bus_reg <= bus_next;
    end
  end

  assign s_axi_bvalid = bus_reg.bvalid;
  assign s_axi_bresp  = bus_reg.bresp;
  assign s_axi_rvalid = bus_reg.rvalid;
  assign s_axi_rdata  = {24'h000000, bus_reg.rdata};
  assign s_axi_rresp  = bus_reg.rresp;

  // ----------------------------------------------------------------------
  // Timer core
  // ----------------------------------------------------------------------
  always_comb begin
    st_next       = st_reg;
    st_next.cap1Q = captureOnePin;
    st_next.cap2Q = captureTwoPin;
    st_next.extQ  = extClockPin;
    st_next.haltQ = haltMode;
    if (haltMode) begin
      if (e1) begin
        st_next.arm1 = 1'b1;
      end
      if (e2) begin
        st_next.arm2 = 1'b1;
      end
    end else begin
      // Prescaler
      st_next.pre = tick ? 3'h0 : st_reg.pre + 3'h1;
      if (st_reg.cr2[`TPIC_CR2_CCHI:`TPIC_CR2_CCLO] == 2'b11) begin
        st_next.pre = 3'h0;
      end
      if (tick) begin
        st_next.cnt = st_reg.cnt + 16'h0001;
      end
      // Two-step flag clearing, set still wins below
      if (rdEn && rdAddr == `TPIC_OFS_SR) begin
        st_next.armed = st_reg.sr;
      end
      if (touched(rdEn, wrEn, rdAddr, wrAddr, `TPIC_OFS_IC1L) &&
          st_reg.armed[`TPIC_SR_CAPTURE_ONE_FLAG]) begin
        st_next.sr[`TPIC_SR_CAPTURE_ONE_FLAG]    = 1'b0;
        st_next.armed[`TPIC_SR_CAPTURE_ONE_FLAG] = 1'b0;
      end
      if (touched(rdEn, wrEn, rdAddr, wrAddr, `TPIC_OFS_OC1L) &&
          st_reg.armed[`TPIC_SR_MATCH_ONE_FLAG]) begin
        st_next.sr[`TPIC_SR_MATCH_ONE_FLAG]    = 1'b0;
        st_next.armed[`TPIC_SR_MATCH_ONE_FLAG] = 1'b0;
      end
      if (touched(rdEn, wrEn, rdAddr, wrAddr, `TPIC_OFS_CL) &&
          st_reg.armed[`TPIC_SR_TOF]) begin
        st_next.sr[`TPIC_SR_TOF]     = 1'b0;
        st_next.armed[`TPIC_SR_TOF]  = 1'b0;
      end
      if (touched(rdEn, wrEn, rdAddr, wrAddr, `TPIC_OFS_IC2L) &&
          st_reg.armed[`TPIC_SR_CAPTURE_TWO_FLAG]) begin
        st_next.sr[`TPIC_SR_CAPTURE_TWO_FLAG]    = 1'b0;
        st_next.armed[`TPIC_SR_CAPTURE_TWO_FLAG] = 1'b0;
      end
      if (touched(rdEn, wrEn, rdAddr, wrAddr, `TPIC_OFS_OC2L) &&
          st_reg.armed[`TPIC_SR_MATCH_TWO_FLAG]) begin
        st_next.sr[`TPIC_SR_MATCH_TWO_FLAG]    = 1'b0;
        st_next.armed[`TPIC_SR_MATCH_TWO_FLAG] = 1'b0;
      end
      if (tick && st_reg.cnt == 16'hffff) begin
        st_next.sr[`TPIC_SR_TOF] = 1'b1;
      end
      // Capture two works in every mode
      if (e2 || (exitHalt && st_reg.arm2)) begin
        st_next.ic2               = st_reg.cnt;
        st_next.sr[`TPIC_SR_CAPTURE_TWO_FLAG] = 1'b1;
        st_next.arm2              = 1'b0;
      end
      if (pwm) begin
        st_next.arm1 = 1'b0;
        if (m1) begin
          st_next.pin1 = st_reg.cr1[`TPIC_CR1_LVL1];
        end
        if (m2) begin
          st_next.pin1 = st_reg.cr1[`TPIC_CR1_LVL2];
          st_next.cnt  = `TPIC_CNT_RST;
          st_next.sr[`TPIC_SR_CAPTURE_ONE_FLAG] = 1'b1;
        end
      end else if (single_pulse_select) begin
        if (e1 || (exitHalt && st_reg.arm1)) begin
          st_next.cnt  = `TPIC_CNT_RST;
          st_next.pin1 = st_reg.cr1[`TPIC_CR1_LVL2];
          st_next.ic1  = `TPIC_OPM_CAP;
          st_next.sr[`TPIC_SR_CAPTURE_ONE_FLAG] = 1'b1;
          st_next.arm1 = 1'b0;
        end else if (m1) begin
          st_next.pin1 = st_reg.cr1[`TPIC_CR1_LVL1];
        end
        if (m2) begin
          st_next.sr[`TPIC_SR_MATCH_TWO_FLAG] = 1'b1;
        end
      end else begin
        if (e1 || (exitHalt && st_reg.arm1)) begin
          st_next.ic1               = st_reg.cnt;
          st_next.sr[`TPIC_SR_CAPTURE_ONE_FLAG] = 1'b1;
          st_next.arm1              = 1'b0;
        end
        if (m1) begin
          st_next.pin1              = st_reg.cr1[`TPIC_CR1_LVL1];
          st_next.sr[`TPIC_SR_MATCH_ONE_FLAG] = 1'b1;
        end
        if (m2) begin
          st_next.pin2              = st_reg.cr1[`TPIC_CR1_LVL2];
          st_next.sr[`TPIC_SR_MATCH_TWO_FLAG] = 1'b1;
        end
        if (st_reg.cr1[`TPIC_CR1_FOL1] && st_reg.cr2[`TPIC_CR2_COMPARE_ONE_PIN_ENABLE]) begin
          st_next.pin1 = st_reg.cr1[`TPIC_CR1_LVL1];
        end
        if (st_reg.cr1[`TPIC_CR1_FOL2] && st_reg.cr2[`TPIC_CR2_COMPARE_TWO_PIN_ENABLE]) begin
          st_next.pin2 = st_reg.cr1[`TPIC_CR1_LVL2];
        end
      end
      // Software writes
      if (wrEn) begin
        unique case (wrAddr)
          `TPIC_OFS_CR1: st_next.cr1 = wrData;
          `TPIC_OFS_CR2: st_next.cr2 = wrData;
          `TPIC_OFS_OC1H: begin
            st_next.oc1[15:8] = wrData;
            st_next.inh[0]    = 1'b1;
          end
          `TPIC_OFS_OC1L: begin
            st_next.oc1[7:0]  = wrData;
            st_next.inh[0]    = 1'b0;
          end
          `TPIC_OFS_OC2H: begin
            st_next.oc2[15:8] = wrData;
            st_next.inh[1]    = 1'b1;
          end
          `TPIC_OFS_OC2L: begin
            st_next.oc2[7:0]  = wrData;
            st_next.inh[1]    = 1'b0;
          end
          `TPIC_OFS_CL: begin
            st_next.cnt = `TPIC_CNT_RST;
            st_next.pre = 3'h0;
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg <= ST_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Pins and interrupt
  // ----------------------------------------------------------------------
  assign compareOnePinOut = st_reg.pin1;
  assign compareOnePinOe  = st_reg.cr2[`TPIC_CR2_COMPARE_ONE_PIN_ENABLE];
  assign compareTwoPinOut = st_reg.pin2;
  assign compareTwoPinOe  = st_reg.cr2[`TPIC_CR2_COMPARE_TWO_PIN_ENABLE];

  assign timerIrq = ~cpuIntMask & (
    (st_reg.cr1[`TPIC_CR1_CAPTURE_IRQ_ENABLE] & (st_reg.sr[`TPIC_SR_CAPTURE_ONE_FLAG] | st_reg.sr[`TPIC_SR_CAPTURE_TWO_FLAG])) |
    (st_reg.cr1[`TPIC_CR1_MATCH_IRQ_ENABLE] & (st_reg.sr[`TPIC_SR_MATCH_ONE_FLAG] | st_reg.sr[`TPIC_SR_MATCH_TWO_FLAG])) |
    (st_reg.cr1[`TPIC_CR1_ROLLOVER_IRQ_ENABLE] & st_reg.sr[`TPIC_SR_TOF]));
  assign wakeFromWait = waitMode & timerIrq;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cbk @(posedge clk); endclocking
  default disable iff (!resetn);

  a_pwm_reload: assert property (
    run && pwm && m2 && !(wrEn && wrAddr == `TPIC_OFS_CL)
    |=> st_reg.cnt == 16'hfffc)
    else $error("Counter not reloaded on period match");

  a_pwm_noflag: assert property (
    run && pwm |=> !$rose(st_reg.sr[`TPIC_SR_MATCH_ONE_FLAG]) && !$rose(st_reg.sr[`TPIC_SR_MATCH_TWO_FLAG]))
    else $error("Match flag set in modulation mode");

  a_pwm_capflag: assert property (
    run && pwm && m2 |=> st_reg.sr[`TPIC_SR_CAPTURE_ONE_FLAG])
    else $error("Capture one flag missing at period match");

  a_pwm_level: assert property (
    run && pwm && m1 && !m2 |=> compareOnePinOut == $past(st_reg.cr1[`TPIC_CR1_LVL1]))
    else $error("Pin one not at first level after pulse match");

  a_pwm_nocap: assert property (
    run && pwm |=> $stable(st_reg.ic1))
    else $error("Capture one loaded in modulation mode");

  a_halt_freeze: assert property (
    ce && haltMode |=> $stable(st_reg.cnt) && $stable(st_reg.sr))
    else $error("Timer moved during halt");

  a_irq_mask: assert property (
    cpuIntMask |-> !timerIrq)
    else $error("Interrupt raised while CPU mask set");

  a_flag_clear: assert property (
    $fell(st_reg.sr[`TPIC_SR_CAPTURE_TWO_FLAG]) |-> $past(st_reg.armed[`TPIC_SR_CAPTURE_TWO_FLAG]))
    else $error("Flag cleared without status read first");

  a_inhibit_oc1: assert property (
    run && !pwm && !single_pulse_select && st_reg.inh[0] |=> !$rose(st_reg.sr[`TPIC_SR_MATCH_ONE_FLAG]))
    else $error("Compare one fired while suspended");

endmodule

`default_nettype wire

// [shared/tpic_cfg.svh]
// Constants of the timer block: offsets, fields, reset values, divider counts
`ifndef TPIC_CFG_SVH
`define TPIC_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TPIC_OFS_CR1   6'h00
`define TPIC_OFS_CR2   6'h04
`define TPIC_OFS_SR    6'h08
`define TPIC_OFS_IC1H  6'h0c
`define TPIC_OFS_IC1L  6'h10
`define TPIC_OFS_OC1H  6'h14
`define TPIC_OFS_OC1L  6'h18
`define TPIC_OFS_OC2H  6'h1c
`define TPIC_OFS_OC2L  6'h20
`define TPIC_OFS_CH    6'h24
`define TPIC_OFS_CL    6'h28
`define TPIC_OFS_ACH   6'h2c
`define TPIC_OFS_ACL   6'h30
`define TPIC_OFS_IC2H  6'h34
`define TPIC_OFS_IC2L  6'h38
`define TPIC_OFS_LAST  6'h38

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TPIC_CR1_CAPTURE_IRQ_ENABLE  7
`define TPIC_CR1_MATCH_IRQ_ENABLE  6
`define TPIC_CR1_ROLLOVER_IRQ_ENABLE  5
`define TPIC_CR1_FOL2  4
`define TPIC_CR1_FOL1  3
`define TPIC_CR1_LVL2  2
`define TPIC_CR1_IED1  1
`define TPIC_CR1_LVL1  0
`define TPIC_CR2_COMPARE_ONE_PIN_ENABLE  7
`define TPIC_CR2_COMPARE_TWO_PIN_ENABLE  6
`define TPIC_CR2_OPM   5
`define TPIC_CR2_PWM   4
`define TPIC_CR2_CCHI  3
`define TPIC_CR2_CCLO  2
`define TPIC_CR2_IED2  1
`define TPIC_CR2_EXED  0
`define TPIC_SR_CAPTURE_ONE_FLAG   7
`define TPIC_SR_MATCH_ONE_FLAG   6
`define TPIC_SR_TOF    5
`define TPIC_SR_CAPTURE_TWO_FLAG   4
`define TPIC_SR_MATCH_TWO_FLAG   3

// ----------------------------------------------------------------------
// Reset values, one-pulse capture value and divider counts
// ----------------------------------------------------------------------
`define TPIC_CNT_RST   16'hfffc
`define TPIC_OC_RST    16'h8000
`define TPIC_OPM_CAP   16'hfffd
`define TPIC_PRE_LAST2 3'h1
`define TPIC_PRE_LAST4 3'h3
`define TPIC_PRE_LAST8 3'h7

`endif

// [shared/tpic_pkg.sv]
// Types of the timer block
package tpic_pkg;
  typedef struct packed {
    logic [2:0]  pre;
    logic [15:0] cnt;
    logic [15:0] oc1;
    logic [15:0] oc2;
    logic [15:0] ic1;
    logic [15:0] ic2;
    logic [7:0]  cr1;
    logic [7:0]  cr2;
    logic [7:0]  sr;
    logic [7:0]  armed;
    logic [1:0]  inh;
    logic        pin1;
    logic        pin2;
    logic        cap1Q;
    logic        cap2Q;
    logic        extQ;
    logic        arm1;
    logic        arm2;
    logic        haltQ;
  } tpic_state_t;

  typedef struct packed {
    logic       awHave;
    logic [5:0] awAddr;
    logic       awBad;
    logic       wHave;
    logic [7:0] wData;
    logic       wEn;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } tpic_bus_t;
endpackage

// [tb/tpic_timer_tb_top.sv]
// Self-checking bench of the timer block
`timescale 1ns/1ps
`default_nettype none
`include "tpic_cfg.svh"

module tpic_timer_tb_top;
  logic        clk = 0;
  logic        resetn = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, seed = 32'h3210;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        mask = 1, halt = 0, waitM = 0;
  logic        pin1, oe1, irq, wake;
  int          mismatches = 0;
  int          n_compared = 0;

  always #12.5 clk = ~clk;

  tpic_timer DUT (.clk(clk), .resetn(resetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .captureOnePin(1'b0), .captureTwoPin(1'b0), .extClockPin(1'b0),
    .compareOnePinOut(pin1), .compareOnePinOe(oe1), .compareTwoPinOut(),
    .compareTwoPinOe(), .cpuIntMask(mask), .haltMode(halt), .waitMode(waitM),
    .timerIrq(irq), .wakeFromWait(wake));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    awaddr <= {26'h0, a};
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(negedge clk);
      ta = awvalid && awready === 1'b1;
      tw = wvalid && wready === 1'b1;
      tb = bvalid === 1'b1;
      @(posedge clk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end while (!tb);
    bready <= 0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    araddr <= {26'h0, a};
    arvalid <= 1;
    rready <= 1;
    do begin
      @(negedge clk);
      ta = arvalid && arready === 1'b1;
      tr = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 0;
    end while (!tr);
    rready <= 0;
    @(posedge clk);
  endtask

  task automatic measure(output int hi, output int per);
    hi = 0;
    do @(negedge clk); while (pin1 !== 1'b0);
    do @(negedge clk); while (pin1 !== 1'b1);
    do begin @(negedge clk); hi++; end while (pin1 === 1'b1);
    per = hi;
    do begin @(negedge clk); per++; end while (pin1 !== 1'b1);
    @(posedge clk);
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d, e;
    logic [1:0]  r;
    int          hi, per, oc1, oc2, bad;
    logic [5:0]  ofs [7] = '{`TPIC_OFS_CR1, `TPIC_OFS_CR2, `TPIC_OFS_SR, `TPIC_OFS_OC1H,
                             `TPIC_OFS_OC1L, `TPIC_OFS_OC2H, `TPIC_OFS_OC2L};
    logic [7:0]  rv [7] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00};
    int          cc [3] = '{1, 0, 2};
    int          pre [3] = '{2, 4, 8};
    repeat (5) @(posedge clk);
    resetn <= 1;
    for (int k = 0; k < 7; k++) begin
      rd(ofs[k], d, r);
      chk(d, rv[k]);
    end
    rd(6'h3c, d, r);
    chk(r, 2'b10);
    e = rnd() & 32'hff;
    wr(`TPIC_OFS_CR1, e[7:0]);
    rd(`TPIC_OFS_CR1, d, r);
    chk(d, e);
    $display("register test done");
    oc1 = 1 + rnd() % 4;
    oc2 = oc1 + 2 + rnd() % 5;
    wr(`TPIC_OFS_CR2, 8'h0c);
    wr(`TPIC_OFS_CL, 8'h00);
    wr(`TPIC_OFS_OC1H, 8'h00);
    wr(`TPIC_OFS_OC1L, oc1[7:0]);
    wr(`TPIC_OFS_OC2H, 8'h00);
    wr(`TPIC_OFS_OC2L, oc2[7:0]);
    wr(`TPIC_OFS_CR1, 8'h81);
    for (int k = 0; k < 3; k++) begin
      wr(`TPIC_OFS_CR2, 8'hb0 | 8'(cc[k] << 2));
      measure(hi, per);
      chk(hi, (oc2 - oc1) * pre[k]);
      chk(per, (oc2 + 5) * pre[k]);
    end
    rd(`TPIC_OFS_SR, d, r);
    chk(d & 32'hc8, 32'h80);
    mask <= 0;
    waitM <= 1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(irq, 1'b1);
    chk(wake, 1'b1);
    @(posedge clk);
    mask <= 1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(irq, 1'b0);
    @(posedge clk);
    waitM <= 0;
    $display("modulation test done");
    wr(`TPIC_OFS_CR1, 8'h85);
    repeat (150) @(posedge clk);
    bad = 0;
    repeat (150) begin @(negedge clk); if (pin1 !== 1'b1) bad++; end
    chk(bad, 0);
    @(posedge clk);
    halt <= 1;
    rd(`TPIC_OFS_CL, e, r);
    repeat (10) @(posedge clk);
    rd(`TPIC_OFS_CL, d, r);
    chk(d, e);
    halt <= 0;
    wr(`TPIC_OFS_CR2, 8'h80);
    wr(`TPIC_OFS_CR1, 8'h09);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({oe1, pin1}, 2'b11);
    @(posedge clk);
    wr(`TPIC_OFS_CR1, 8'h08);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(pin1, 1'b0);
    @(posedge clk);
    $display("level and halt test done");
    conclude();
  end
endmodule
`default_nettype wire
